/* File: common/hmba_defines.vh */
// constants for the shared-bus arbitration block
`ifndef HMBA_DEFINES_VH
`define HMBA_DEFINES_VH
`define HMBA_NUM_REQ 6
`define HMBA_NUM_PROC 4
`define HMBA_ID_W 3
`define HMBA_ID_NONE 3'h0
`define HMBA_ID_LAST 3'h6
`endif

/* File: hdl/hmba_sync.v */
// two-flop synchroniser for a vector of pin inputs
`default_nettype none
module hmba_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] stage;
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage <= INIT;
      dout <= INIT;
    end
    else
    begin
      stage <= din;
      dout <= stage;
    end
  end
endmodule // hmba_sync
`default_nettype wire

/* File: hdl/hmba_arbiter.v */
// shared-bus arbitration for one processor of the module
`include "hmba_defines.vh"
`default_nettype none
module hmba_arbiter (
  input wire clock,
  input wire rst,
  input wire [2:0] proc_identity,
  input wire rotating_priority_sel,
  input wire host_bus_request_n,
  input wire host_bus_grant_n_in,
  input wire proc_a_select_n,
  input wire proc_b_select_n,
  input wire proc_c_select_n,
  input wire proc_d_select_n,
  input wire ack_active_drive_sel,
  input wire access_wait,
  input wire [5:0] proc_bus_request_n_in,
  input wire core_priority_access_n_in,
  input wire want_bus,
  input wire dma_cycle,
  input wire core_priority_req,
  output reg host_bus_grant_n_out,
  output reg host_bus_grant_n_oe,
  output reg host_acknowledge_out,
  output reg host_acknowledge_oe,
  output reg [5:0] proc_bus_request_n_out,
  output reg [5:0] proc_bus_request_n_oe,
  output reg core_priority_access_n_oe,
  output reg bus_drive_oe,
  output reg bus_master,
  output reg dma_hold,
  output reg [2:0] current_master
);
  localparam ST_IDLE = 3'h1;
  localparam ST_OWN = 3'h2;
  localparam ST_HOST = 3'h4;

  wire [5:0] req_s;
  wire hbr_s;
  wire hbg_s;
  wire [3:0] cs_s;
  wire cpa_s;
  wire rotating_priority_sel_s;
  hmba_sync #(.WIDTH(13), .INIT(13'h1fff)) u_sync (
    .clock(clock),
    .rst(rst),
    .din({proc_bus_request_n_in, host_bus_request_n, host_bus_grant_n_in,
          proc_d_select_n, proc_c_select_n, proc_b_select_n, proc_a_select_n,
          core_priority_access_n_in}),
    .dout({req_s, hbr_s, hbg_s, cs_s, cpa_s})
  );
  hmba_sync #(.WIDTH(1), .INIT(1'h0)) u_sync_rp (
    .clock(clock),
    .rst(rst),
    .din(rotating_priority_sel),
    .dout(rotating_priority_sel_s)
  );

  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] next_master;
  reg [2:0] winner;
  reg [2:0] cand;
  reg found;
  reg [3:0] rsum;
  integer i;
  wire host_req = ~hbr_s;
  wire [5:0] active_req;
  wire my_id_ok = (proc_identity != `HMBA_ID_NONE) && (proc_identity <= `HMBA_ID_LAST);
  wire [2:0] my_idx = proc_identity - 3'h1;
  wire [3:0] cs_act = ~cs_s;
  wire my_cs = (proc_identity >= 3'h1 && proc_identity <= 3'h4) ?
    cs_act[my_idx[1:0]] : 1'b0;

  // request vector: others monitored, own taken from local intent
  genvar g;
  generate
    for (g = 0; g < `HMBA_NUM_REQ; g = g + 1)
    begin : g_req
      assign active_req[g] = (my_id_ok && my_idx == g) ? proc_bus_request_n_out[g] == 1'b0
                                                       : ~req_s[g];
    end
  endgenerate

  // winner: fixed is lowest id first; rotating starts after current master
  always @*
  begin
    winner = current_master;
    found = 1'b0;
    cand = 3'h0;
    rsum = 4'h0;
    for (i = 0; i < `HMBA_NUM_REQ; i = i + 1)
    begin
      // four-bit sum so that the wrap past line six is not lost
      rsum = ({1'b0, current_master} + {1'b0, i[2:0]}) % 4'h6;
      if (rotating_priority_sel_s)
        cand = (current_master == `HMBA_ID_NONE) ? i[2:0] + 3'h1 : rsum[2:0] + 3'h1;
      else
        cand = i[2:0] + 3'h1;
      if (!found && active_req[cand - 3'h1])
      begin
        winner = cand;
        found = 1'b1;
      end
    end
    if (!found)
      winner = `HMBA_ID_NONE;
  end

  // bus ownership and host handoff
  always @*
  begin
    next_state = state;
    next_master = current_master;
    case (state)
      ST_IDLE:
      begin
        if (host_req && !bus_master)
          next_state = ST_IDLE;
        else if (host_req && bus_master)
          next_state = ST_HOST;
        else if (current_master == `HMBA_ID_NONE || active_req[current_master - 3'h1] == 1'b0
                 || rotating_priority_sel_s)
          next_master = winner;
        if (!host_req && next_master == proc_identity && my_id_ok)
          next_state = ST_OWN;
      end
      ST_OWN:
      begin
        if (host_req)
          next_state = ST_HOST;
        else if (!want_bus || (winner != proc_identity && rotating_priority_sel_s && found
                 && active_req[winner - 3'h1] && winner != current_master))
        begin
          next_state = ST_IDLE;
          next_master = winner;
        end
      end
      ST_HOST:
      begin
        if (!host_req)
          next_state = ST_OWN;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      current_master <= `HMBA_ID_NONE;
      bus_master <= 1'b0;
      bus_drive_oe <= 1'b0;
      host_bus_grant_n_out <= 1'b1;
      host_bus_grant_n_oe <= 1'b0;
      host_acknowledge_out <= 1'b0;
      host_acknowledge_oe <= 1'b0;
      proc_bus_request_n_out <= 6'h3f;
      proc_bus_request_n_oe <= 6'h00;
      core_priority_access_n_oe <= 1'b0;
      dma_hold <= 1'b0;
    end
    else
    begin
      state <= next_state;
      current_master <= next_master;
      bus_master <= (next_state == ST_OWN) || (next_state == ST_HOST);
      bus_drive_oe <= (next_state == ST_OWN);
      host_bus_grant_n_out <= ~(next_state == ST_HOST);
      host_bus_grant_n_oe <= (next_state == ST_OWN) || (next_state == ST_HOST);
      if (my_id_ok)
      begin
        proc_bus_request_n_out <= ~(6'h01 << my_idx) | {6{~want_bus}};
        proc_bus_request_n_oe <= 6'h01 << my_idx;
      end
      else
      begin
        proc_bus_request_n_out <= 6'h3f;
        proc_bus_request_n_oe <= 6'h00;
      end
      if (my_cs && host_req)
      begin
        host_acknowledge_out <= ~access_wait;
        host_acknowledge_oe <= ack_active_drive_sel | access_wait;
      end
      else
      begin
        host_acknowledge_out <= 1'b0;
        host_acknowledge_oe <= 1'b0;
      end
      core_priority_access_n_oe <= core_priority_req && !bus_master;
      dma_hold <= bus_master && !cpa_s && dma_cycle;
    end
  end
endmodule // hmba_arbiter
`default_nettype wire

/* File: test/hmba_host.sv */
// host model: holds its request while it needs the bus
`default_nettype none
module hmba_host (
  input wire logic clock,
  input wire logic need,
  output logic req_n,
  output logic sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req_n = 1'b1;
  always @(posedge clock) req_n <= #1 !need;
  assign sel_n = req_n;
endmodule // hmba_host
`default_nettype wire

/* File: test/hmba_arbiter_chk.sv */
// port checker for the arbiter
`default_nettype none
module hmba_chk (
  input wire clock,
  input wire rst,
  input wire [2:0] proc_identity,
  input wire host_bus_request_n,
  input wire proc_a_select_n,
  input wire ack_active_drive_sel,
  input wire host_bus_grant_n_out,
  input wire host_bus_grant_n_oe,
  input wire host_acknowledge_out,
  input wire host_acknowledge_oe,
  input wire [5:0] proc_bus_request_n_oe,
  input wire bus_drive_oe,
  input wire bus_master,
  input wire [2:0] current_master
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic g = !host_bus_grant_n_out && host_bus_grant_n_oe;
  wire logic [6:0] own = 7'h01 << proc_identity;
  grant_owner_a: assert property (host_bus_grant_n_oe |-> bus_master) else $error("grant");
  bus_release_a: assert property (g |-> !bus_drive_oe) else $error("release");
  grant_hold_a: assert property (g && !$past(host_bus_request_n, 2) |=> g) else $error("hold");
  grant_give_a: assert property (bus_master && host_bus_request_n ##1
    !host_bus_request_n [*4] |-> g) else $error("give");
  ack_cause_a: assert property (host_acknowledge_oe |-> !$past(host_bus_request_n, 3)
    && !$past(proc_a_select_n, 3)) else $error("ack drive");
  ack_drain_a: assert property (host_acknowledge_oe && host_acknowledge_out
    |-> ack_active_drive_sel) else $error("open drain");
  own_line_a: assert property ((proc_bus_request_n_oe & ~own[6:1]) == 6'h00)
    else $error("line");
  host_first_a: assert property (g |=> $stable(current_master)) else $error("host");
endmodule // hmba_chk
bind hmba_arbiter hmba_chk chk (.*);
`default_nettype wire

/* File: test/tb_hmba_arbiter.sv */
// bench for the shared-bus arbiter
`default_nettype none
module tb_hmba_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, need = 0, rot = 0, ads = 0, aw = 0, want = 0, cpr = 0, cpx = 0;
  wire logic dh;
  logic [5:0] ext = 6'h3f;
  wire logic hbr_n, sel_n, gn, goe, ao, aoe, cpoe, bdoe, bm;
  wire logic [5:0] ro, roe;
  wire logic [2:0] cm;
  int bad_count = 0, cmp_count = 0;
  initial forever #4 clock = !clock;
  hmba_host host (.clock(clock), .need(need), .req_n(hbr_n), .sel_n(sel_n));
  hmba_arbiter uut (.clock(clock), .rst(rst), .proc_identity(3'h1),
    .rotating_priority_sel(rot), .host_bus_request_n(hbr_n),
    .host_bus_grant_n_in(goe ? gn : 1'b1), .proc_a_select_n(sel_n),
    .proc_b_select_n(1'b1), .proc_c_select_n(1'b1), .proc_d_select_n(1'b1),
    .ack_active_drive_sel(ads), .access_wait(aw), .proc_bus_request_n_in(ext & (~roe | ro)),
    .core_priority_access_n_in(!cpoe && !cpx),
    .want_bus(want), .dma_cycle(want),
    .core_priority_req(cpr), .host_bus_grant_n_out(gn), .host_bus_grant_n_oe(goe),
    .host_acknowledge_out(ao), .host_acknowledge_oe(aoe), .proc_bus_request_n_out(ro),
    .proc_bus_request_n_oe(roe), .core_priority_access_n_oe(cpoe), .bus_drive_oe(bdoe),
    .bus_master(bm), .dma_hold(dh), .current_master(cm));
  task test_done;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  initial
  begin
    step(8);
    chk({gn, goe, aoe, bdoe, cpoe}, 6'h10);
    chk(ro & ~roe, 6'h3f);
    rst = 0;
    want = 1;
    for (int i = 0; i < 20 && bm !== 1'b1; i++) step(1);
    chk({bm, cm}, 4'h9);
    chk({roe, ro}, 12'h07e);
    cpx = 1;
    step(4);
    chk(dh, 1'b1);
    cpx = 0;
    step(4);
    chk(dh, 1'b0);
    need = 1;
    aw = 1;
    for (int i = 0; i < 20 && gn !== 1'b0; i++) step(1);
    chk({gn, goe, bdoe}, 3'b010);
    step(2);
    chk({aoe, ao}, 2'b10);
    aw = 0;
    step(4);
    chk(aoe, 1'b0);
    ads = 1;
    step(4);
    chk({aoe, ao}, 2'b11);
    need = 0;
    step(3);
    chk(gn, 1'b0);
    step(4);
    chk({gn, bdoe, aoe}, 3'b110);
    ads = 0;
    rot = 1;
    ext = 6'h3d;
    want = 0;
    for (int i = 0; i < 20 && cm !== 3'h2; i++) step(1);
    chk({bm, cm}, 4'h2);
    cpr = 1;
    step(5);
    chk(cpoe, 1'b1);
    test_done;
  end
endmodule // tb_hmba_arbiter
`default_nettype wire
